// File: drpt_map.vh
// drpt_map.vh: shared constants for the packet timing block
// assumes: included by bare name from the packet timing module and the bench
`ifndef DRPT_MAP_VH
`define DRPT_MAP_VH

// ---------------------------------------------------------------
// packet framing, in channel cycles
// ---------------------------------------------------------------
`define DRPT_PACKET_CYCLES   3'h4
`define DRPT_ROW_CORE_EXTRA  4'h1
`define DRPT_CAC_MIN         4'h8
`define DRPT_CAC_MAX         4'hC
`define DRPT_CAC_RESET       4'h8
`define DRPT_STORE_LATENCY   4'h6
`define DRPT_CLOSE_OFFSET    4'h4
`define DRPT_DELAY_DEPTH     12

// ---------------------------------------------------------------
// column command codes on the column bus
// ---------------------------------------------------------------
`define DRPT_COL_NOP         3'h0
`define DRPT_COL_READ        3'h1
`define DRPT_COL_STORE       3'h2
`define DRPT_COL_READ_AC     3'h3
`define DRPT_COL_STORE_AC    3'h4
`define DRPT_COL_RETIRE      3'h5
`define DRPT_COL_CLOSE       3'h6

`endif

// File: drpt_delay_line.v
// drpt_delay_line.v: tapped shift line of tagged events
// assumes: advance is a one-cycle pulse per channel cycle, tap >= 1
`timescale 1ns/1ps

module drpt_delay_line
#(
   parameter DEPTH = 12,
   parameter W     = 5,
   parameter TAPW  = 4
)
(
   input  wire            sys_clk,
   input  wire            rst_n,
   input  wire            advance,
   input  wire            inValid,
   input  wire [W-1:0]    inData,
   input  wire [TAPW-1:0] tap,
   output wire            outValid,
   output wire [W-1:0]    outData
);

   reg [DEPTH:1] vld;
   reg [W-1:0]   dat [1:DEPTH];

   // ------------------------------------------------------------
   // stages
   // ------------------------------------------------------------
   // an event entered at advance k is seen at stage n on advance k+n
   genvar g;
   generate
      for (g = 1; g <= DEPTH; g = g + 1)
      begin : stage
         always @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               vld[g] <= 1'b0;
               dat[g] <= {W{1'b0}};
            end
            else if (advance)
            begin
               if (g == 1)
               begin
                  vld[g] <= inValid;
                  dat[g] <= inData;
               end
               else
               begin
                  vld[g] <= vld[g-1];
                  dat[g] <= dat[g-1];
               end
            end
         end
      end
   endgenerate

   assign outValid = advance & vld[tap];
   assign outData  = dat[tap];

endmodule

// File: drpt_packet_timing.v
// drpt_packet_timing.v: device-side packet timing of a DRAM channel
// assumes: channel pins change on the falling channel clock edge and
// are sampled at its rising edge; readLatency is static on sys_clk
//
// Function
// [RULE1] controller waits row-to-column delay before column command
// [RULE2] core sees row-to-column one cycle longer
// [RULE3] read data returns 8 to 12 cycles later
// [RULE4] controller drives store data six cycles later
// [RULE5] controller spaces column packets four cycles
// [RULE6] every packet occupies exactly four cycles
// [RULE7] controller waits eight cycles before retire or mask
// [RULE8] autoclose commands imply a close four cycles later
// [RULE9] controller waits four cycles after read before close
// [RULE10] controller waits four cycles after retire before close
// [RULE11] column and extended closes share row-close constraints
// [RULE12] controller separates same-bank opens by 28 cycles
// [RULE13] bank stays open 20 cycles, at most 64 us
// [RULE14] controller waits eight cycles after close before open
// [RULE15] controller spaces opens within device eight cycles
// [RULE16] controller tracks counters and holds packets back
`timescale 1ns/1ps
`include "drpt_map.vh"

module drpt_packet_timing
#(
   parameter BANKW = 5
)
(
   input  wire                  sys_clk,
   input  wire                  rst_n,
   input  wire                  chanClk,
   input  wire                  rowStart,
   input  wire                  rowOpen,
   input  wire [BANKW-1:0]      rowBank,
   input  wire                  colStart,
   input  wire [2:0]            colCmd,
   input  wire [BANKW-1:0]      colBank,
   input  wire                  extStart,
   input  wire                  extClose,
   input  wire [BANKW-1:0]      extBank,
   input  wire [3:0]            readLatency,
   output reg                   chanTick,
   output reg                   coreOpenValid,
   output reg  [BANKW-1:0]      coreOpenBank,
   output reg  [(1<<BANKW)-1:0] coreCloseMask,
   output reg                   coreColValid,
   output reg                   coreColStore,
   output reg  [BANKW-1:0]      coreColBank,
   output reg                   readDataStart,
   output reg  [BANKW-1:0]      readDataBank,
   output reg                   writeDataCapture,
   output reg  [BANKW-1:0]      writeDataBank
);

   localparam BANKS = 1 << BANKW;
   localparam PINW  = 3 * BANKW + 9;

   // ------------------------------------------------------------
   // pin synchronisers and channel clock edge
   // ------------------------------------------------------------
   wire [PINW-1:0] pinRaw;
   reg  [PINW-1:0] pinMeta;
   reg  [PINW-1:0] pinSync;
   reg             clkPrev;

   assign pinRaw = {chanClk, rowStart, rowOpen, rowBank, colStart,
                    colCmd, colBank, extStart, extClose, extBank};

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pinMeta <= {PINW{1'b0}};
         pinSync <= {PINW{1'b0}};
         clkPrev <= 1'b0;
      end
      else
      begin
         pinMeta <= pinRaw;
         pinSync <= pinMeta;
         clkPrev <= pinSync[PINW-1];
      end
   end

   wire             sClk      = pinSync[PINW-1];
   wire             sRowStart = pinSync[PINW-2];
   wire             sRowOpen  = pinSync[PINW-3];
   wire [BANKW-1:0] sRowBank  = pinSync[PINW-4 -: BANKW];
   wire             sColStart = pinSync[2*BANKW+5];
   wire [2:0]       sColCmd   = pinSync[2*BANKW+4 -: 3];
   wire [BANKW-1:0] sColBank  = pinSync[2*BANKW+1 -: BANKW];
   wire             sExtStart = pinSync[BANKW+1];
   wire             sExtClose = pinSync[BANKW];
   wire [BANKW-1:0] sExtBank  = pinSync[BANKW-1:0];
   wire             tick      = sClk & ~clkPrev;

   // ------------------------------------------------------------
   // packet framing: a start inside a running packet is ignored
   // ------------------------------------------------------------
   wire [2:0] busStart = {sExtStart, sColStart, sRowStart};
   wire [2:0] accept;
   reg  [2:0] busyCnt [0:2];

   genvar b;
   generate
      for (b = 0; b < 3; b = b + 1)
      begin : frame
         assign accept[b] = tick & busStart[b] & (busyCnt[b] == 3'h0);
         always @(posedge sys_clk or negedge rst_n)
         begin
            if (!rst_n)
               busyCnt[b] <= 3'h0;
            else if (accept[b])
               busyCnt[b] <= `DRPT_PACKET_CYCLES - 3'h1;  // see [RULE6]
            else if (tick && busyCnt[b] != 3'h0)
               busyCnt[b] <= busyCnt[b] - 3'h1;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // command decode
   // ------------------------------------------------------------
   function [BANKS-1:0] bankMask;
      input [BANKW-1:0] bank;
      begin
         bankMask = {{(BANKS-1){1'b0}}, 1'b1} << bank;
      end
   endfunction

   function [3:0] clampLatency;
      input [3:0] v;
      begin
         if (v < `DRPT_CAC_MIN)
            clampLatency = `DRPT_CAC_MIN;
         else if (v > `DRPT_CAC_MAX)
            clampLatency = `DRPT_CAC_MAX;
         else
            clampLatency = v;
      end
   endfunction

   reg [BANKS-1:0] storeAcPend;

   wire rowOpenAcc  = accept[0] & sRowOpen;
   wire rowCloseAcc = accept[0] & ~sRowOpen;
   wire colRead     = (sColCmd == `DRPT_COL_READ) |
                      (sColCmd == `DRPT_COL_READ_AC);
   wire colStore    = (sColCmd == `DRPT_COL_STORE) |
                      (sColCmd == `DRPT_COL_STORE_AC);
   wire colAccess   = accept[1] & (colRead | colStore);
   wire colImplied  = accept[1] &
                      ((sColCmd == `DRPT_COL_READ_AC) |
                       (sColCmd == `DRPT_COL_CLOSE) |
                       ((sColCmd == `DRPT_COL_RETIRE) &
                        storeAcPend[sColBank]));     // see [RULE8]
   wire extImplied  = accept[2] & sExtClose;

   // an autoclose store arms its bank; the retire consumes it
   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         storeAcPend <= {BANKS{1'b0}};
      else if (accept[1])
      begin
         case (sColCmd)
            `DRPT_COL_STORE_AC:
               storeAcPend <= storeAcPend | bankMask(sColBank);
            `DRPT_COL_STORE,
            `DRPT_COL_RETIRE:
               storeAcPend <= storeAcPend & ~bankMask(sColBank);
            default:
               storeAcPend <= storeAcPend;
         endcase
      end
   end

   // ------------------------------------------------------------
   // delay lines on the channel cycle
   // ------------------------------------------------------------
   wire             colCoreDly;
   wire [BANKW:0]   colCoreDat;
   wire             readDly;
   wire [BANKW-1:0] readDlyBank;
   wire             storeDly;
   wire [BANKW-1:0] storeDlyBank;
   wire             colCloseDly;
   wire [BANKW-1:0] colCloseBank;
   wire             extCloseDly;
   wire [BANKW-1:0] extCloseBank;

   // columns reach the core one cycle late, so the core sees the
   // row-to-column gap one longer than the pins show
   drpt_delay_line #(.DEPTH(`DRPT_DELAY_DEPTH), .W(BANKW+1), .TAPW(4))
   uColCore (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .advance  (tick),
      .inValid  (colAccess),
      .inData   ({colStore, sColBank}),
      .tap      (`DRPT_ROW_CORE_EXTRA),                 // see [RULE2]
      .outValid (colCoreDly),
      .outData  (colCoreDat)
   );

   drpt_delay_line #(.DEPTH(`DRPT_DELAY_DEPTH), .W(BANKW), .TAPW(4))
   uRead (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .advance  (tick),
      .inValid  (colAccess & colRead),
      .inData   (sColBank),
      .tap      (clampLatency(readLatency)),            // see [RULE3]
      .outValid (readDly),
      .outData  (readDlyBank)
   );

   // store data is taken at the fixed slot the controller must hit
   drpt_delay_line #(.DEPTH(`DRPT_DELAY_DEPTH), .W(BANKW), .TAPW(4))
   uStore (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .advance  (tick),
      .inValid  (colAccess & colStore),
      .inData   (sColBank),
      .tap      (`DRPT_STORE_LATENCY),                  // see [RULE4]
      .outValid (storeDly),
      .outData  (storeDlyBank)
   );

   // two lines so a column and an extended close never collide
   drpt_delay_line #(.DEPTH(`DRPT_DELAY_DEPTH), .W(BANKW), .TAPW(4))
   uColClose (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .advance  (tick),
      .inValid  (colImplied),
      .inData   (sColBank),
      .tap      (`DRPT_CLOSE_OFFSET),                   // see [RULE8]
      .outValid (colCloseDly),
      .outData  (colCloseBank)
   );

   drpt_delay_line #(.DEPTH(`DRPT_DELAY_DEPTH), .W(BANKW), .TAPW(4))
   uExtClose (
      .sys_clk  (sys_clk),
      .rst_n    (rst_n),
      .advance  (tick),
      .inValid  (extImplied),
      .inData   (sExtBank),
      .tap      (`DRPT_CLOSE_OFFSET),                   // see [RULE8]
      .outValid (extCloseDly),
      .outData  (extCloseBank)
   );

   // ------------------------------------------------------------
   // core side outputs
   // ------------------------------------------------------------
   wire [BANKS-1:0] next_coreCloseMask =
      ({BANKS{rowCloseAcc}} & bankMask(sRowBank)) |
      ({BANKS{colCloseDly}} & bankMask(colCloseBank)) |
      ({BANKS{extCloseDly}} & bankMask(extCloseBank));

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chanTick         <= 1'b0;
         coreOpenValid    <= 1'b0;
         coreOpenBank     <= {BANKW{1'b0}};
         coreCloseMask    <= {BANKS{1'b0}};
         coreColValid     <= 1'b0;
         coreColStore     <= 1'b0;
         coreColBank      <= {BANKW{1'b0}};
         readDataStart    <= 1'b0;
         readDataBank     <= {BANKW{1'b0}};
         writeDataCapture <= 1'b0;
         writeDataBank    <= {BANKW{1'b0}};
      end
      else
      begin
         chanTick         <= tick;
         coreOpenValid    <= rowOpenAcc;
         coreCloseMask    <= next_coreCloseMask;
         coreColValid     <= colCoreDly;
         readDataStart    <= readDly;
         writeDataCapture <= storeDly;
         if (rowOpenAcc)
            coreOpenBank <= sRowBank;
         if (colCoreDly)
         begin
            coreColStore <= colCoreDat[BANKW];
            coreColBank  <= colCoreDat[BANKW-1:0];
         end
         if (readDly)
            readDataBank <= readDlyBank;
         if (storeDly)
            writeDataBank <= storeDlyBank;
      end
   end

endmodule

// File: drpt_ctrl_model.sv
// drpt_ctrl_model.sv: behavioural controller driving the packet pins
// assumes: chanClk comes from the bench, pins move on its falling edge
`timescale 1ns/1ps

module drpt_ctrl_model
(
   input  wire       chanClk,
   output reg        rowStart,
   output reg        rowOpen,
   output reg  [4:0] rowBank,
   output reg        colStart,
   output reg  [2:0] colCmd,
   output reg  [4:0] colBank,
   output reg        extStart,
   output reg        extClose,
   output reg  [4:0] extBank
);
   initial
   begin
      {rowStart, rowOpen, rowBank, colStart, colCmd, colBank} = 0;
      {extStart, extClose, extBank} = 0;
   end

   // fields count only in the first cycle; afterwards show the inverse
   // so a late sample cannot pass by luck
   task col(input [2:0] cmd, input [4:0] bank, input integer len);
      begin
         @(negedge chanClk);
         {colStart, colCmd, colBank} = {1'b1, cmd, bank};
         @(negedge chanClk);
         {colStart, colCmd, colBank} = {1'b0, ~cmd, ~bank};
         repeat (len - 2) @(negedge chanClk);
      end
   endtask

   task row(input open, input [4:0] bank);
      begin
         @(negedge chanClk);
         {rowStart, rowOpen, rowBank} = {1'b1, open, bank};
         @(negedge chanClk);
         {rowStart, rowOpen, rowBank} = {1'b0, ~open, ~bank};
         repeat (2) @(negedge chanClk);
      end
   endtask

   task ext(input cls, input [4:0] bank);
      begin
         @(negedge chanClk);
         {extStart, extClose, extBank} = {1'b1, cls, bank};
         @(negedge chanClk);
         {extStart, extClose, extBank} = {1'b0, ~cls, ~bank};
         repeat (2) @(negedge chanClk);
      end
   endtask

   // callers pad gaps to meet controller minimums, except t_refuse, which starts a column two cycles after the previous one
   task idle(input integer n);
      repeat (n) @(negedge chanClk);
   endtask
endmodule

// File: drpt_timing_checker.sv
// drpt_timing_checker.sv: port-level timing checks of the packet block
// assumes: bound to drpt_packet_timing, readLatency static while busy
`timescale 1ns/1ps

module drpt_timing_checker
#(
   parameter BANKW = 5
)
(
   input wire                  sys_clk,
   input wire                  rst_n,
   input wire [3:0]            readLatency,
   input wire                  chanTick,
   input wire                  coreOpenValid,
   input wire [(1<<BANKW)-1:0] coreCloseMask,
   input wire                  coreColValid,
   input wire                  coreColStore,
   input wire                  readDataStart,
   input wire                  writeDataCapture
);
   // -----------------------------------------------------------
   // helper: column events aged in channel ticks
   // -----------------------------------------------------------
   reg  [15:0] rdq;
   reg  [15:0] wrq;
   reg  [2:0]  colAge;
   wire [3:0]  lat = (readLatency < 4'h8) ? 4'h8 :
                     (readLatency > 4'hC) ? 4'hC : readLatency;
   // the core column lags its pin tick by one, hence the minus two
   wire        rdDue = rdq[lat - 4'h2];
   wire        wrDue = wrq[4];

   always @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdq <= 16'h0000;
         wrq <= 16'h0000;
         colAge <= 3'h4;
      end
      else if (chanTick)
      begin
         rdq <= {rdq[14:0], coreColValid & ~coreColStore};
         wrq <= {wrq[14:0], coreColValid & coreColStore};
         if (coreColValid)
            colAge <= 3'h0;
         else if (colAge < 3'h4)
            colAge <= colAge + 3'h1;
      end
   end

   // -----------------------------------------------------------
   // assertions
   // -----------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   AST_RD_LAT: assert property (chanTick && rdDue |-> readDataStart)
      else $error("read data missing at its latency");
   AST_RD_CAUSE: assert property (readDataStart |->
      chanTick && rdDue) else $error("read data unasked");
   AST_WR_LAT: assert property (chanTick && wrDue |-> writeDataCapture)
      else $error("store data not captured at six");
   AST_WR_CAUSE: assert property (writeDataCapture |-> wrDue)
      else $error("store capture without store");
   AST_COL_SPACE: assert property (coreColValid |-> colAge >= 3'h3)
      else $error("column packet inside running packet");
   AST_COL_TICK: assert property (coreColValid |-> chanTick)
      else $error("column taken off tick");
   AST_OPEN_TICK: assert property (coreOpenValid |-> chanTick)
      else $error("open not on tick");
   AST_CLOSE_TICK: assert property (|coreCloseMask |-> chanTick)
      else $error("close not on tick");
endmodule

bind drpt_packet_timing drpt_timing_checker #(.BANKW(BANKW)) chk (
   .sys_clk          (sys_clk),
   .rst_n            (rst_n),
   .readLatency      (readLatency),
   .chanTick         (chanTick),
   .coreOpenValid    (coreOpenValid),
   .coreCloseMask    (coreCloseMask),
   .coreColValid     (coreColValid),
   .coreColStore     (coreColStore),
   .readDataStart    (readDataStart),
   .writeDataCapture (writeDataCapture)
);

// File: tb_drpt_packet_timing.sv
// tb_drpt_packet_timing.sv: self-checking bench of the packet block
// assumes: controller model drives pins, 800 ns channel clock
`timescale 1ns/1ps
`include "drpt_map.vh"

module tb_drpt_packet_timing;
   reg         sys_clk = 0;
   reg         rst_n = 0;
   reg         chanClk = 0;
   reg  [3:0]  readLatency = 4'h8;
   wire        rowStart, rowOpen, colStart, extStart, extClose;
   wire [4:0]  rowBank, colBank, extBank;
   wire [2:0]  colCmd;
   wire        chanTick, coreOpenValid, coreColValid, coreColStore;
   wire        readDataStart, writeDataCapture;
   wire [4:0]  coreOpenBank, coreColBank, readDataBank, writeDataBank;
   wire [31:0] coreCloseMask;
   integer     miscompares = 0, nChecks = 0, cyc = 0, nCol = 0, nCl = 0;
   integer     tCol = 0, tRd = 0, tWr = 0, tCl = 0, tOpen = 0, i, n;
   reg  [31:0] clMask = 0;
   reg         stSeen = 0;
   reg         armCol = 0;
   integer     tPin = 0;

   // tPin marks the first tick after colStart last rose, whether that start was taken or refused
   always @(posedge colStart) armCol = 1;

   always #50 sys_clk = ~sys_clk;
   initial
   begin
      #137;
      forever #400 chanClk = ~chanClk;
   end

   drpt_ctrl_model ctl (
      .chanClk  (chanClk),
      .rowStart (rowStart),
      .rowOpen  (rowOpen),
      .rowBank  (rowBank),
      .colStart (colStart),
      .colCmd   (colCmd),
      .colBank  (colBank),
      .extStart (extStart),
      .extClose (extClose),
      .extBank  (extBank)
   );
   drpt_packet_timing dut (
      .sys_clk          (sys_clk),
      .rst_n            (rst_n),
      .chanClk          (chanClk),
      .rowStart         (rowStart),
      .rowOpen          (rowOpen),
      .rowBank          (rowBank),
      .colStart         (colStart),
      .colCmd           (colCmd),
      .colBank          (colBank),
      .extStart         (extStart),
      .extClose         (extClose),
      .extBank          (extBank),
      .readLatency      (readLatency),
      .chanTick         (chanTick),
      .coreOpenValid    (coreOpenValid),
      .coreOpenBank     (coreOpenBank),
      .coreCloseMask    (coreCloseMask),
      .coreColValid     (coreColValid),
      .coreColStore     (coreColStore),
      .coreColBank      (coreColBank),
      .readDataStart    (readDataStart),
      .readDataBank     (readDataBank),
      .writeDataCapture (writeDataCapture),
      .writeDataBank    (writeDataBank)
   );

   // sample settled outputs away from the launching edge
   always @(negedge sys_clk)
   begin
      cyc = cyc + 1;
      if (coreColValid === 1'b1)
         {tCol, nCol, stSeen} = {cyc, nCol + 1, coreColStore};
      if (readDataStart === 1'b1) tRd = cyc;
      if (writeDataCapture === 1'b1) tWr = cyc;
      if (coreOpenValid === 1'b1) tOpen = cyc;
      if (chanTick === 1'b1 && armCol)
      begin
         tPin = cyc;
         armCol = 0;
      end
      if (|coreCloseMask)
         {tCl, nCl, clMask} = {cyc, nCl + 1, coreCloseMask};
      if (cyc >= 20000)
      begin
         miscompares = miscompares + 1;
         close_out;
      end
   end

   task chk(input string name, input [31:0] seen, input [31:0] exp);
      begin
         nChecks = nChecks + 1;
         if (seen !== exp)
         begin
            miscompares = miscompares + 1;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
         end
      end
   endtask

   task t_read;
      for (i = 7; i <= 13; i = i + 1)
      begin
         @(negedge sys_clk) readLatency = i;
         ctl.col(`DRPT_COL_READ, i, 4);
         ctl.idle(14);
         chk("rdLat", tRd - tPin, 8 * (i < 8 ? 8 : i > 12 ? 12 : i));
         chk("rdBank", readDataBank, i);
         chk("rdKind", stSeen, 0);
      end
   endtask

   task t_store;
      begin
         ctl.col(`DRPT_COL_STORE, 7, 4);
         ctl.idle(5); // retire waits 8 or more cycles
         chk("wrLat", tWr - tPin, 48);
         chk("wrBank", writeDataBank, 7);
         chk("wrKind", stSeen, 1);
         n = nCl;
         ctl.col(`DRPT_COL_RETIRE, 7, 4);
         ctl.idle(8);
         chk("plainRetire", nCl - n, 0);
         ctl.col(`DRPT_COL_STORE_AC, 4, 4);
         ctl.idle(5);
         ctl.col(`DRPT_COL_RETIRE, 4, 4);
         ctl.idle(8);
         chk("acRetire", clMask, 32'h10);
         chk("acRetireT", tCl - tPin, 32);
      end
   endtask

   task t_close;
      begin
         ctl.col(`DRPT_COL_READ_AC, 3, 4);
         ctl.idle(6);
         chk("rdAc", clMask, 32'h8);
         chk("rdAcT", tCl - tPin, 32);
         ctl.col(`DRPT_COL_CLOSE, 5, 4);
         ctl.idle(6);
         chk("colCl", clMask, 32'h20);
         chk("colClT", tCl - tPin, 32);
         ctl.ext(1, 9);
         ctl.idle(6);
         chk("extCl", clMask, 32'h200);
         ctl.row(0, 11);
         ctl.idle(4);
         chk("rowCl", clMask, 32'h800);
         n = nCl;
         ctl.ext(0, 2);
         ctl.idle(6);
         chk("extNoCl", nCl - n, 0);
      end
   endtask

   task t_row;
      begin
         ctl.row(1, 2);
         ctl.idle(3); // column 7 cycles after the open
         ctl.col(`DRPT_COL_READ, 2, 4);
         ctl.idle(14);
         chk("rcdCore", tCol - tOpen, 64);
         chk("colLag", tCol - tPin, 8);
         chk("openBank", coreOpenBank, 2);
      end
   endtask

   task t_refuse;
      begin
         n = nCol;
         ctl.col(`DRPT_COL_READ, 1, 2);
         ctl.col(`DRPT_COL_READ, 2, 4);
         ctl.col(`DRPT_COL_NOP, 3, 4);
         ctl.idle(14);
         chk("colCount", nCol - n, 1);
         chk("colBank", coreColBank, 1);
      end
   endtask

   task close_out;
      begin
         $display("checks %0d mismatches %0d", nChecks, miscompares);
         if (miscompares == 0 && nChecks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask

   initial
   begin
      repeat (20) @(posedge sys_clk);
      @(negedge sys_clk) rst_n = 1;
      repeat (4) @(negedge sys_clk);
      t_read;
      $display("test read done");
      t_store;
      $display("test store done");
      t_close;
      $display("test close done");
      t_row;
      $display("test row done");
      t_refuse;
      $display("test refuse done");
      close_out;
   end
endmodule
